// *** hdl/fub_flash_map.vh ***
// Constants for the nonvolatile unlock and byte program controller.
// Assumes an 8-bit register port and a 16-bit byte address space.
`ifndef FUB_FLASH_MAP_VH
`define FUB_FLASH_MAP_VH

// Register indexes on the register port.
`define FUB_REG_CTRL1     4'h0
`define FUB_REG_CTRL2     4'h1
`define FUB_REG_CTRL2_N   4'h2
`define FUB_REG_PKEY      4'h3
`define FUB_REG_DKEY      4'h4
`define FUB_REG_STATUS    4'h5
`define FUB_REG_ROLOCK    4'h6
`define FUB_REG_BOOTSZ    4'h7

// Field positions.
`define FUB_C1_FIX        0
`define FUB_C1_IRQ_EN     1
`define FUB_C2_OPT        7
`define FUB_ST_WPERR      0
`define FUB_ST_PUL        1
`define FUB_ST_EOP        2
`define FUB_ST_DUL        3
`define FUB_ST_BUSY       4

// Reset values.
`define FUB_CTRL2_RST     8'h00
`define FUB_CTRL2_N_RST   8'hFF
`define FUB_OPT_RST       8'h00

// Keys and special values.
`define FUB_KEY_A         8'h56
`define FUB_KEY_B         8'hAE
`define FUB_LOCK_ON       8'hAA

// Address map.
`define FUB_MAIN_BASE     16'h8000
`define FUB_DATA_BASE     16'h4000
`define FUB_DATA_END      16'h427F
`define FUB_OPT_BASE      16'h4800
`define FUB_OPT_END       16'h487F
`define FUB_PAGE_SHIFT    6
`define FUB_OPT_IDX_LOCK  16'h4800
`define FUB_OPT_IDX_BOOT  16'h4801

// Timing.
`define FUB_CLK_NS        40
`define FUB_T_ERASE_NS    3000000
`define FUB_T_WRITE_NS    3000000

`endif

// *** hdl/fub_flash_ctrl.v ***
// Unlock, protection and byte program control for program memory,
// data memory and configuration bytes.
// Assumes a synchronous CPU bus, a debug access path and an array
// that reports whether the addressed word is blank.
//
// What this block does
// - Option writes need enable set, complement clear.
// - Lock byte 0xAA refuses debug memory access.
// - Removing lock in-circuit key_unlock_system-erases everything.
// - Reset leaves program and data areas protected.
// - Boot code pages always stay write protected.
// - First program key compared with 0x56.
// - Bad first program key locks until reset.
// - Second program key compared with 0xAE.
// - Both program keys good sets program unlocked.
// - Clearing program unlocked restores protection.
// - First data key 0xAE; mismatch allows retry.
// - Second data key 0x56; mismatch locks.
// - Both data keys unlock; clearing relocks.
// - Option write needs data keys plus enables.
// - Data reads blocked while program memory writes.
// - Unlocked write starts byte program; stall for main writes, or any write without RWW_PRESENT.
// - Completion sets operation complete flag.
// - Protected write skipped, sets error flag.
// - Interrupt when enabled and either flag set.
// - Non-blank word erased first, blank skipped.
// - Fixed-time bit always erases before writing.
//
// Chosen here: the plain strobed port and the address map.
`timescale 1ns/1ns
`include "fub_flash_map.vh"

module fub_flash_ctrl #(
	parameter RWW_PRESENT = 1,
	parameter ERASE_CYC   = `FUB_T_ERASE_NS / `FUB_CLK_NS,
	parameter WRITE_CYC   = `FUB_T_WRITE_NS / `FUB_CLK_NS
) (
	// Clock and reset.
	input  wire        clk,
	input  wire        sys_rst,
	// Register port.
	input  wire [3:0]  reg_addr,
	input  wire [7:0]  reg_wdata,
	input  wire        reg_wr,
	input  wire        reg_rd,
	output reg  [7:0]  reg_rdata,
	// CPU memory bus.
	input  wire [15:0] mem_addr,
	input  wire [7:0]  mem_wdata,
	input  wire        mem_wr,
	// Debug access path.
	input  wire        in_circuit_programming,
	input  wire [15:0] dbg_addr,
	input  wire [7:0]  dbg_wdata,
	input  wire        dbg_wr,
	input  wire        dbg_rd,
	output reg         dbg_refused,
	// Array side.
	input  wire        arr_word_blank,
	output reg  [15:0] arr_addr,
	output reg  [7:0]  arr_wdata,
	output reg         arr_erase_en,
	output reg         arr_prog_en,
	output reg         arr_key_unlock_system_erase,
	// Core side.
	output reg         cpu_stall,
	output reg         data_read_block,
	output reg         memory_irq
);

	localparam K_FIRST  = 2'd0;
	localparam K_SECOND = 2'd1;
	localparam K_OPEN   = 2'd2;
	localparam K_LOCK   = 2'd3;

	localparam S_IDLE  = 2'd0;
	localparam S_ERASE = 2'd1;
	localparam S_WRITE = 2'd2;
	localparam S_KEY_UNLOCK_SYSTEM  = 2'd3;

	localparam [1:0] RG_NONE = 2'd0;
	localparam [1:0] RG_MAIN = 2'd1;
	localparam [1:0] RG_DATA = 2'd2;
	localparam [1:0] RG_OPT  = 2'd3;

	// Classifies an address into the memory region it belongs to.
	function [1:0] fub_region;
		input [15:0] a;
		begin
			if (a >= `FUB_MAIN_BASE) begin
				fub_region = RG_MAIN;
			end else if (a >= `FUB_DATA_BASE && a <= `FUB_DATA_END) begin
				fub_region = RG_DATA;
			end else if (a >= `FUB_OPT_BASE && a <= `FUB_OPT_END) begin
				fub_region = RG_OPT;
			end else begin
				fub_region = RG_NONE;
			end
		end
	endfunction

	// Control and status state.
	reg        fix_time;
	reg        irq_en;
	reg [7:0]  ctrl2;
	reg [7:0]  ctrl2_n;
	reg [1:0]  pkey_state;
	reg [1:0]  dkey_state;
	reg        program_area_unlocked;
	reg        data_area_unlocked;
	reg        operation_complete_flag;
	reg        protected_page_write_error;
	reg [7:0]  readout_lock_byte;
	reg [7:0]  boot_code_area;
	reg [1:0]  op_state;
	reg [1:0]  op_region;
	reg [19:0] op_timer;

	// Request merging and protection checks.
	wire        rd_locked   = (readout_lock_byte == `FUB_LOCK_ON);
	wire [1:0]  dbg_region  = fub_region(dbg_addr);
	wire        dbg_mem_hit = (dbg_region == RG_MAIN) || (dbg_region == RG_DATA);
	wire        dbg_block   = rd_locked && dbg_mem_hit;
	wire        dbg_is_lift = in_circuit_programming && rd_locked
		&& (dbg_addr == `FUB_OPT_IDX_LOCK) && (dbg_wdata != `FUB_LOCK_ON);
	wire        idle        = (op_state == S_IDLE);
	wire        cpu_go      = mem_wr && idle;
	wire        dbg_go      = dbg_wr && idle && !mem_wr && !dbg_block;
	wire        req         = cpu_go || dbg_go;
	wire [15:0] req_addr    = cpu_go ? mem_addr : dbg_addr;
	wire [7:0]  req_data    = cpu_go ? mem_wdata : dbg_wdata;
	wire [1:0]  req_region  = fub_region(req_addr);
	wire [16:0] boot_end    = {1'b0, `FUB_MAIN_BASE}
		+ ({9'h000, boot_code_area} << `FUB_PAGE_SHIFT);
	wire        in_boot     = ({1'b0, req_addr} < boot_end);
	wire        opt_enabled = ctrl2[`FUB_C2_OPT] && !ctrl2_n[`FUB_C2_OPT];
	reg         allowed;

	// Decides whether the addressed area is open for writing.
	always @* begin
		allowed = 1'b0;
		if (req_region == RG_MAIN) begin
			allowed = program_area_unlocked && !in_boot;
		end else if (req_region == RG_DATA) begin
			allowed = data_area_unlocked;
		end else if (req_region == RG_OPT) begin
			allowed = data_area_unlocked && opt_enabled;
		end
	end

	wire start_ok  = req && allowed && !dbg_is_lift;
	wire start_bad = req && !allowed && (req_region != RG_NONE);
	wire start_lift = dbg_wr && idle && !mem_wr && dbg_is_lift;
	wire op_done   = (op_state == S_WRITE) && (op_timer == 20'h00000);
	wire key_unlock_system_done = (op_state == S_KEY_UNLOCK_SYSTEM) && (op_timer == 20'h00000);

	// Register port write decode.
	wire wr_c1  = reg_wr && (reg_addr == `FUB_REG_CTRL1);
	wire wr_c2  = reg_wr && (reg_addr == `FUB_REG_CTRL2);
	wire wr_c2n = reg_wr && (reg_addr == `FUB_REG_CTRL2_N);
	wire wr_pk  = reg_wr && (reg_addr == `FUB_REG_PKEY);
	wire wr_dk  = reg_wr && (reg_addr == `FUB_REG_DKEY);
	wire wr_st  = reg_wr && (reg_addr == `FUB_REG_STATUS);
	wire rd_st  = reg_rd && (reg_addr == `FUB_REG_STATUS);

	// Control registers.
	always @(posedge clk) begin
		if (sys_rst) begin
			fix_time <= 1'b0;
			irq_en   <= 1'b0;
			ctrl2    <= `FUB_CTRL2_RST;
			ctrl2_n  <= `FUB_CTRL2_N_RST;
		end else begin
			if (wr_c1) begin
				fix_time <= reg_wdata[`FUB_C1_FIX];
				irq_en   <= reg_wdata[`FUB_C1_IRQ_EN];
			end
			if (wr_c2) begin
				ctrl2 <= reg_wdata;
			end
			if (wr_c2n) begin
				ctrl2_n <= reg_wdata;
			end
		end
	end

	// Program key sequencer; values are compared, never stored.
	always @(posedge clk) begin
		if (sys_rst) begin
			pkey_state            <= K_FIRST;
			program_area_unlocked <= 1'b0;
		end else begin
			if (wr_pk) begin
				case (pkey_state)
				K_FIRST: begin
					if (reg_wdata == `FUB_KEY_A) begin
						pkey_state <= K_SECOND;
					end else begin
						pkey_state <= K_LOCK;
					end
				end
				K_SECOND: begin
					if (reg_wdata == `FUB_KEY_B) begin
						pkey_state <= K_OPEN;
					end else begin
						pkey_state <= K_LOCK;
					end
				end
				default: begin
					pkey_state <= pkey_state;
				end
				endcase
			end
			if (wr_pk && pkey_state == K_SECOND && reg_wdata == `FUB_KEY_B) begin
				program_area_unlocked <= 1'b1;
			end else if (wr_st && !reg_wdata[`FUB_ST_PUL]) begin
				program_area_unlocked <= 1'b0;
			end
		end
	end

	// Data key sequencer; a bad first key leaves room for a retry.
	always @(posedge clk) begin
		if (sys_rst) begin
			dkey_state         <= K_FIRST;
			data_area_unlocked <= 1'b0;
		end else begin
			if (wr_dk) begin
				case (dkey_state)
				K_FIRST: begin
					if (reg_wdata == `FUB_KEY_B) begin
						dkey_state <= K_SECOND;
					end else begin
						dkey_state <= K_FIRST;
					end
				end
				K_SECOND: begin
					if (reg_wdata == `FUB_KEY_A) begin
						dkey_state <= K_OPEN;
					end else begin
						dkey_state <= K_LOCK;
					end
				end
				default: begin
					dkey_state <= dkey_state;
				end
				endcase
			end
			if (wr_dk && dkey_state == K_SECOND && reg_wdata == `FUB_KEY_A) begin
				data_area_unlocked <= 1'b1;
			end else if (wr_st && !reg_wdata[`FUB_ST_DUL]) begin
				data_area_unlocked <= 1'b0;
			end
		end
	end

	// Event flags clear on a status read; a new event in that cycle wins.
	always @(posedge clk) begin
		if (sys_rst) begin
			operation_complete_flag    <= 1'b0;
			protected_page_write_error <= 1'b0;
		end else begin
			if (op_done) begin
				operation_complete_flag <= 1'b1;
			end else if (rd_st) begin
				operation_complete_flag <= 1'b0;
			end
			if (start_bad) begin
				protected_page_write_error <= 1'b1;
			end else if (rd_st) begin
				protected_page_write_error <= 1'b0;
			end
		end
	end

	// Byte program sequencer with conditional word erase.
	always @(posedge clk) begin
		if (sys_rst) begin
			op_state  <= S_IDLE;
			op_region <= RG_NONE;
			op_timer  <= 20'h00000;
			arr_addr  <= 16'h0000;
			arr_wdata <= 8'h00;
		end else begin
			case (op_state)
			S_IDLE: begin
				if (start_lift) begin
					op_state <= S_KEY_UNLOCK_SYSTEM;
					op_timer <= ERASE_CYC[19:0] - 20'h00001;
				end else if (start_ok) begin
					op_region <= req_region;
					arr_addr  <= req_addr;
					arr_wdata <= req_data;
					if (fix_time || !arr_word_blank) begin
						op_state <= S_ERASE;
						op_timer <= ERASE_CYC[19:0] - 20'h00001;
					end else begin
						op_state <= S_WRITE;
						op_timer <= WRITE_CYC[19:0] - 20'h00001;
					end
				end
			end
			S_ERASE: begin
				if (op_timer == 20'h00000) begin
					op_state <= S_WRITE;
					op_timer <= WRITE_CYC[19:0] - 20'h00001;
				end else begin
					op_timer <= op_timer - 20'h00001;
				end
			end
			S_WRITE: begin
				if (op_timer == 20'h00000) begin
					op_state  <= S_IDLE;
					op_region <= RG_NONE;
				end else begin
					op_timer <= op_timer - 20'h00001;
				end
			end
			default: begin
				if (op_timer == 20'h00000) begin
					op_state <= S_IDLE;
				end else begin
					op_timer <= op_timer - 20'h00001;
				end
			end
			endcase
		end
	end

	// Configuration bytes, rewritten when a program to them completes.
	always @(posedge clk) begin
		if (sys_rst) begin
			readout_lock_byte <= `FUB_OPT_RST;
			boot_code_area    <= `FUB_OPT_RST;
		end else if (start_lift) begin
			readout_lock_byte <= `FUB_OPT_RST;
			boot_code_area    <= `FUB_OPT_RST;
		end else if (op_done && op_region == RG_OPT) begin
			if (arr_addr == `FUB_OPT_IDX_LOCK) begin
				readout_lock_byte <= arr_wdata;
			end else if (arr_addr == `FUB_OPT_IDX_BOOT) begin
				boot_code_area <= arr_wdata;
			end
		end
	end

	// Array strobes and core-facing indications, all registered.
	always @(posedge clk) begin
		if (sys_rst) begin
			arr_erase_en    <= 1'b0;
			arr_prog_en     <= 1'b0;
			arr_key_unlock_system_erase  <= 1'b0;
			cpu_stall       <= 1'b0;
			data_read_block <= 1'b0;
			dbg_refused     <= 1'b0;
			memory_irq      <= 1'b0;
		end else begin
			arr_erase_en   <= (op_state == S_ERASE) && (op_timer != 20'h00000);
			arr_prog_en    <= (op_state == S_WRITE) && (op_timer != 20'h00000);
			arr_key_unlock_system_erase <= start_lift || ((op_state == S_KEY_UNLOCK_SYSTEM) && !key_unlock_system_done);
			// Main writes always stall; data writes only without concurrent access.
			cpu_stall <= (op_state != S_IDLE) && !op_done && !key_unlock_system_done
				&& ((op_region == RG_MAIN) || (RWW_PRESENT == 0));
			data_read_block <= (op_state != S_IDLE) && !op_done
				&& (op_region == RG_MAIN);
			dbg_refused <= (dbg_rd || dbg_wr) && dbg_block;
			memory_irq  <= irq_en
				&& (operation_complete_flag || protected_page_write_error);
		end
	end

	// Register read data, one cycle after the strobe.
	always @(posedge clk) begin
		if (sys_rst) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			if (reg_addr == `FUB_REG_CTRL1) begin
				reg_rdata <= {6'h00, irq_en, fix_time};
			end else if (reg_addr == `FUB_REG_CTRL2) begin
				reg_rdata <= ctrl2;
			end else if (reg_addr == `FUB_REG_CTRL2_N) begin
				reg_rdata <= ctrl2_n;
			end else if (reg_addr == `FUB_REG_STATUS) begin
				reg_rdata <= {3'h0, (op_state != S_IDLE), data_area_unlocked,
					operation_complete_flag, program_area_unlocked,
					protected_page_write_error};
			end else if (reg_addr == `FUB_REG_ROLOCK) begin
				reg_rdata <= readout_lock_byte;
			end else if (reg_addr == `FUB_REG_BOOTSZ) begin
				reg_rdata <= boot_code_area;
			end else begin
				reg_rdata <= 8'h00;
			end
		end else begin
			reg_rdata <= 8'h00;
		end
	end

endmodule

// *** bench/fub_array_model.sv ***
// Behavioural array that remembers which words hold programmed data.
// Assumes the controller drives the arr_ ports and samples arr_word_blank.
`timescale 1ns/1ns

module fub_array_model (
	// Clock.
	input  wire        clk,
	// Controller side.
	input  wire [15:0] mem_addr,
	input  wire [15:0] arr_addr,
	input  wire [7:0]  arr_wdata,
	input  wire        arr_erase_en,
	input  wire        arr_prog_en,
	input  wire        arr_key_unlock_system_erase,
	output wire        arr_word_blank
);
	reg [255:0] used;

	initial used = 256'h0;

	// A word reads blank until a nonzero byte lands in it.
	assign arr_word_blank = !used[mem_addr[9:2]];

	// Erases clear a word, programs of nonzero data mark it.
	always @(posedge clk) begin
		if (arr_key_unlock_system_erase)
			used <= 256'h0;
		else if (arr_erase_en)
			used[arr_addr[9:2]] <= 1'b0;
		else if (arr_prog_en && arr_wdata != 8'h00)
			used[arr_addr[9:2]] <= 1'b1;
	end
endmodule

// *** bench/fub_flash_ctrl_asserts.sv ***
// Port-level checker for the unlock and byte program controller.
// Assumes it is bound to the controller and sees only its ports.
`timescale 1ns/1ns
`include "fub_flash_map.vh"

module fub_flash_ctrl_asserts #(
	parameter RWW_PRESENT = 1,
	parameter ERASE_CYC   = 8,
	parameter WRITE_CYC   = 6
) (
	// Clock and reset.
	input wire        clk,
	input wire        sys_rst,
	// Register port.
	input wire [3:0]  reg_addr,
	input wire [7:0]  reg_wdata,
	input wire        reg_wr,
	// Requests.
	input wire        mem_wr,
	input wire        dbg_wr,
	input wire        dbg_rd,
	input wire        in_circuit_programming,
	// Outputs watched.
	input wire        dbg_refused,
	input wire [15:0] arr_addr,
	input wire        arr_erase_en,
	input wire        arr_prog_en,
	input wire        arr_key_unlock_system_erase,
	input wire        cpu_stall,
	input wire        data_read_block,
	input wire        memory_irq
);
	reg       irq_en;
	reg [7:0] pcnt;
	reg [7:0] ecnt;

	// Shadow of the interrupt enable and run lengths of the array phases.
	always @(posedge clk) begin
		if (sys_rst)
			irq_en <= 1'b0;
		else if (reg_wr && reg_addr == `FUB_REG_CTRL1)
			irq_en <= reg_wdata[`FUB_C1_IRQ_EN];
		pcnt <= arr_prog_en ? pcnt + 8'h01 : 8'h00;
		ecnt <= arr_erase_en ? ecnt + 8'h01 : 8'h00;
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	AST_RESET_QUIET: assert property (disable iff (1'b0) $past(sys_rst) |->
		!(cpu_stall || arr_prog_en || arr_erase_en || arr_key_unlock_system_erase || memory_irq))
		else $error("array or core outputs active after reset");
	AST_PHASE_EXCL: assert property (!(arr_erase_en && arr_prog_en))
		else $error("erase and write phases overlap");
	AST_WRITE_LEN: assert property ($fell(arr_prog_en) |-> pcnt == WRITE_CYC - 1)
		else $error("write phase has the wrong length");
	AST_ERASE_LEN: assert property ($fell(arr_erase_en) |->
		ecnt == ERASE_CYC - 1 ##[0:1] arr_prog_en)
		else $error("erase phase not followed by write phase");
	AST_MAIN_STALL: assert property (arr_prog_en && arr_addr >= `FUB_MAIN_BASE |->
		cpu_stall && data_read_block)
		else $error("main program without stall or data read block");
	AST_DATA_RWW: assert property (arr_prog_en && arr_addr < `FUB_MAIN_BASE &&
		RWW_PRESENT != 0 |-> !cpu_stall && !data_read_block)
		else $error("data program stalls core");
	AST_ARRAY_CAUSE: assert property (($rose(arr_erase_en) || ($rose(arr_prog_en) &&
		!$past(arr_erase_en) && !$past(arr_erase_en, 2))) |->
		$past(mem_wr || dbg_wr) || $past(mem_wr || dbg_wr, 2))
		else $error("array operation without a write");
	AST_IRQ_MASK: assert property (!irq_en && !$past(irq_en) && !$past(irq_en, 2) |->
		!memory_irq)
		else $error("interrupt raised while disabled");
	AST_REFUSE_CAUSE: assert property (dbg_refused |-> $past(dbg_rd || dbg_wr))
		else $error("debug refusal without a debug access");
	AST_KEY_UNLOCK_SYSTEM_ICP: assert property ($rose(arr_key_unlock_system_erase) |-> $past(in_circuit_programming))
		else $error("key_unlock_system erase outside in-circuit mode");

	// Main scenarios reached.
	COV_ERASE: cover property ($rose(arr_erase_en));
	COV_DATA_WRITE: cover property (arr_prog_en && !cpu_stall);
	COV_IRQ: cover property ($rose(memory_irq));
	COV_KEY_UNLOCK_SYSTEM: cover property ($rose(arr_key_unlock_system_erase));
	COV_REFUSED: cover property (dbg_refused);
endmodule

bind fub_flash_ctrl fub_flash_ctrl_asserts #(.RWW_PRESENT(RWW_PRESENT),
	.ERASE_CYC(ERASE_CYC), .WRITE_CYC(WRITE_CYC)) u_chk (
	.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_wr(reg_wr), .mem_wr(mem_wr), .dbg_wr(dbg_wr), .dbg_rd(dbg_rd),
	.in_circuit_programming(in_circuit_programming), .dbg_refused(dbg_refused),
	.arr_addr(arr_addr), .arr_erase_en(arr_erase_en), .arr_prog_en(arr_prog_en),
	.arr_key_unlock_system_erase(arr_key_unlock_system_erase), .cpu_stall(cpu_stall),
	.data_read_block(data_read_block), .memory_irq(memory_irq));

// *** bench/tb_flash_unlock_byte_program.sv ***
// Self-checking bench for the unlock and byte program controller.
// Assumes the array model beside the design and the bound checker.
`timescale 1ns/1ns
`include "fub_flash_map.vh"

module tb_flash_unlock_byte_program;
	reg         clk;
	reg         sys_rst;
	reg  [3:0]  reg_addr;
	reg  [7:0]  reg_wdata;
	reg         reg_wr;
	reg         reg_rd;
	reg  [15:0] mem_addr;
	reg  [7:0]  mem_wdata;
	reg         mem_wr;
	reg         in_circuit_programming;
	reg  [15:0] dbg_addr;
	reg  [7:0]  dbg_wdata;
	reg         dbg_wr;
	reg         dbg_rd;
	wire [7:0]  reg_rdata;
	wire        dbg_refused;
	wire        data_read_block;
	wire [15:0] arr_addr;
	wire [7:0]  arr_wdata;
	wire        arr_erase_en;
	wire        arr_prog_en;
	wire        arr_key_unlock_system_erase;
	wire        arr_word_blank;
	wire        cpu_stall;
	wire        memory_irq;
	reg         erase_seen;
	reg         stall_seen;
	reg         pseen;
	reg         blk_seen;
	reg  [7:0]  wd;
	reg  [11:0] rows [0:6];
	integer     failures;
	integer     n_compared;
	integer     i;

	fub_flash_ctrl #(.ERASE_CYC(8), .WRITE_CYC(6)) DUT (
		.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mem_addr(mem_addr),
		.mem_wdata(mem_wdata), .mem_wr(mem_wr),
		.in_circuit_programming(in_circuit_programming),
		.dbg_addr(dbg_addr), .dbg_wdata(dbg_wdata), .dbg_wr(dbg_wr), .dbg_rd(dbg_rd),
		.dbg_refused(dbg_refused), .arr_word_blank(arr_word_blank), .arr_addr(arr_addr),
		.arr_wdata(arr_wdata), .arr_erase_en(arr_erase_en), .arr_prog_en(arr_prog_en),
		.arr_key_unlock_system_erase(arr_key_unlock_system_erase), .cpu_stall(cpu_stall),
		.data_read_block(data_read_block),
		.memory_irq(memory_irq));

	fub_array_model u_arr (.clk(clk), .mem_addr(mem_addr), .arr_addr(arr_addr),
		.arr_wdata(arr_wdata), .arr_erase_en(arr_erase_en), .arr_prog_en(arr_prog_en),
		.arr_key_unlock_system_erase(arr_key_unlock_system_erase), .arr_word_blank(arr_word_blank));

	// Clock of 40 ns period.
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	// Records what the array and core outputs did during an operation.
	always @(negedge clk) begin
		if (arr_erase_en)
			erase_seen = 1'b1;
		if (cpu_stall)
			stall_seen = 1'b1;
		if (data_read_block)
			blk_seen = 1'b1;
		if (arr_prog_en) begin
			pseen = 1'b1;
			wd = arr_wdata;
		end
	end

	task chk(input [7:0] seen, input [7:0] exp, input [8*8:1] what);
		begin
			n_compared = n_compared + 1;
			if (seen !== exp) begin
				failures = failures + 1;
				$display("unexpected %0s: expected %h seen %h", what, exp, seen);
			end
		end
	endtask

	task wr(input [3:0] a, input [7:0] d);
		begin
			@(posedge clk);
			reg_addr  <= a;
			reg_wdata <= d;
			reg_wr    <= 1'b1;
			@(posedge clk);
			reg_wr <= 1'b0;
		end
	endtask

	task rchk(input [3:0] a, input [7:0] e, input [8*8:1] what);
		begin
			@(posedge clk);
			reg_addr <= a;
			reg_rd   <= 1'b1;
			@(posedge clk);
			reg_rd <= 1'b0;
			#1;
			chk(reg_rdata, e, what);
		end
	endtask

	// A memory write that the controller should refuse.
	task bad(input [15:0] a);
		begin
			@(posedge clk);
			mem_addr <= a;
			mem_wr   <= 1'b1;
			@(posedge clk);
			mem_wr <= 1'b0;
			repeat (3) @(posedge clk);
			#1;
		end
	endtask

	// A one-cycle access on the debug path, made in in-circuit mode.
	task dbg(input w, input [15:0] a, input [7:0] d);
		begin
			@(posedge clk);
			in_circuit_programming <= 1'b1;
			dbg_addr  <= a;
			dbg_wdata <= d;
			dbg_wr    <= w;
			dbg_rd    <= !w;
			@(posedge clk);
			dbg_wr <= 1'b0;
			dbg_rd <= 1'b0;
			#1;
		end
	endtask

	// An accepted byte program, waited for under a bounded count.
	task prog(input [15:0] a, input [7:0] d, input er, input stl);
		begin
			erase_seen = 1'b0;
			stall_seen = 1'b0;
			pseen = 1'b0;
			blk_seen = 1'b0;
			@(posedge clk);
			mem_addr  <= a;
			mem_wdata <= d;
			mem_wr    <= 1'b1;
			@(posedge clk);
			mem_wr <= 1'b0;
			for (i = 0; i < 40 && !(pseen && !arr_prog_en); i = i + 1)
				@(negedge clk);
			chk(pseen && !arr_prog_en, 1'b1, "done");
			chk(erase_seen, er, "erase");
			chk(stall_seen, stl, "stall");
			chk(blk_seen, stl, "rdblock");
			chk(wd, d, "wdata");
		end
	endtask

	task rst;
		begin
			@(posedge clk);
			sys_rst <= 1'b1;
			repeat (4) @(posedge clk);
			sys_rst <= 1'b0;
		end
	endtask

	task wrap_up;
		begin
			$display("compared %0d, failures %0d", n_compared, failures);
			if (failures == 0 && n_compared > 0)
				$display("ALL TESTS PASSED");
			else
				$display("TESTS FAILED");
			$finish;
		end
	endtask

	// Reset table: register index beside its expected reset value.
	initial begin
		rows[0] = {`FUB_REG_STATUS, 8'h00};
		rows[1] = {`FUB_REG_CTRL1, 8'h00};
		rows[2] = {`FUB_REG_CTRL2, `FUB_CTRL2_RST};
		rows[3] = {`FUB_REG_CTRL2_N, `FUB_CTRL2_N_RST};
		rows[4] = {`FUB_REG_ROLOCK, 8'h00};
		rows[5] = {`FUB_REG_BOOTSZ, 8'h00};
		rows[6] = {4'hF, 8'h00};
	end

	// Main sequence.
	initial begin
		failures = 0;
		n_compared = 0;
		sys_rst = 1'b1;
		reg_addr = 4'h0;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		mem_addr = 16'h0000;
		mem_wdata = 8'h00;
		mem_wr = 1'b0;
		in_circuit_programming = 1'b0;
		dbg_addr = 16'h0000;
		dbg_wdata = 8'h00;
		dbg_wr = 1'b0;
		dbg_rd = 1'b0;
		rst;
		for (i = 0; i < 7; i = i + 1)
			rchk(rows[i][11:8], rows[i][7:0], "reset");
		$display("test reset values done");
		wr(`FUB_REG_CTRL1, 8'h02);
		bad(16'h8100);
		chk(memory_irq, 1'b1, "irq");
		rchk(`FUB_REG_STATUS, 8'h01, "status");
		repeat (3) @(posedge clk);
		#1;
		chk(memory_irq, 1'b0, "irq");
		wr(`FUB_REG_CTRL1, 8'h00);
		$display("test protected write done");
		wr(`FUB_REG_PKEY, `FUB_KEY_A);
		wr(`FUB_REG_PKEY, `FUB_KEY_B);
		wr(`FUB_REG_DKEY, 8'h11);
		wr(`FUB_REG_DKEY, `FUB_KEY_B);
		wr(`FUB_REG_DKEY, `FUB_KEY_A);
		rchk(`FUB_REG_STATUS, 8'h0A, "status");
		prog(16'h8100, 8'h5A, 1'b0, 1'b1);
		rchk(`FUB_REG_STATUS, 8'h0E, "status");
		prog(16'h8101, 8'h00, 1'b1, 1'b1);
		wr(`FUB_REG_CTRL1, 8'h01);
		prog(16'h8200, 8'h33, 1'b1, 1'b1);
		wr(`FUB_REG_CTRL1, 8'h00);
		prog(16'h4010, 8'h77, 1'b0, 1'b0);
		$display("test programming done");
		bad(16'h4801);
		rchk(`FUB_REG_STATUS, 8'h0F, "status");
		wr(`FUB_REG_CTRL2, 8'h80);
		bad(16'h4801);
		rchk(`FUB_REG_STATUS, 8'h0B, "status");
		wr(`FUB_REG_CTRL2_N, 8'h7F);
		prog(16'h4801, 8'h01, 1'b0, 1'b0);
		rchk(`FUB_REG_STATUS, 8'h0E, "status");
		rchk(`FUB_REG_BOOTSZ, 8'h01, "boot");
		bad(16'h8000);
		rchk(`FUB_REG_STATUS, 8'h0B, "status");
		prog(16'h8040, 8'h22, 1'b0, 1'b1);
		$display("test option and boot area done");
		prog(16'h4800, `FUB_LOCK_ON, 1'b1, 1'b0);
		rchk(`FUB_REG_ROLOCK, `FUB_LOCK_ON, "lock");
		dbg(1'b0, 16'h8100, 8'h00);
		chk(dbg_refused, 1'b1, "refused");
		dbg(1'b1, 16'h4010, 8'h55);
		chk(dbg_refused, 1'b1, "refused");
		dbg(1'b1, `FUB_OPT_IDX_LOCK, 8'h00);
		chk(arr_key_unlock_system_erase, 1'b1, "key_unlock_system");
		repeat (10) @(posedge clk);
		#1;
		chk(arr_key_unlock_system_erase, 1'b0, "key_unlock_system");
		rchk(`FUB_REG_ROLOCK, 8'h00, "lock");
		rchk(`FUB_REG_BOOTSZ, 8'h00, "boot");
		dbg(1'b0, 16'h8100, 8'h00);
		chk(dbg_refused, 1'b0, "refused");
		$display("test readout lock done");
		wr(`FUB_REG_STATUS, 8'h00);
		rchk(`FUB_REG_STATUS, 8'h04, "status");
		bad(16'h8100);
		bad(16'h4010);
		rchk(`FUB_REG_STATUS, 8'h01, "status");
		$display("test relock done");
		rst;
		wr(`FUB_REG_PKEY, 8'h00);
		wr(`FUB_REG_PKEY, `FUB_KEY_A);
		wr(`FUB_REG_PKEY, `FUB_KEY_B);
		wr(`FUB_REG_DKEY, `FUB_KEY_B);
		wr(`FUB_REG_DKEY, 8'h00);
		wr(`FUB_REG_DKEY, `FUB_KEY_B);
		wr(`FUB_REG_DKEY, `FUB_KEY_A);
		rchk(`FUB_REG_STATUS, 8'h00, "status");
		bad(16'h8100);
		rchk(`FUB_REG_STATUS, 8'h01, "status");
		$display("test key lockout done");
		rst;
		wr(`FUB_REG_PKEY, `FUB_KEY_A);
		wr(`FUB_REG_PKEY, 8'h00);
		wr(`FUB_REG_PKEY, `FUB_KEY_A);
		wr(`FUB_REG_PKEY, `FUB_KEY_B);
		wr(`FUB_REG_DKEY, `FUB_KEY_B);
		wr(`FUB_REG_DKEY, `FUB_KEY_A);
		rchk(`FUB_REG_STATUS, 8'h08, "status");
		$display("test second key and reset done");
		wrap_up;
	end

	// Cuts a hang short well beyond the expected run of about 250 cycles.
	initial begin
		#200000;
		failures = failures + 1;
		wrap_up;
	end
endmodule
